// ---- common/tlf_pkg.sv ----
// constants shared by the temperature-indexed fan control core
package tlf_pkg;
    localparam logic [7:0] TLF_ADDR_FAN_FAIL_DUTY = 8'h03;
    localparam logic [7:0] TLF_ADDR_IDEALITY = 8'h05;
    localparam logic [7:0] TLF_ADDR_RHL_H = 8'h06;
    localparam logic [7:0] TLF_ADDR_RHL_L = 8'h07;
    localparam logic [7:0] TLF_ADDR_LOT_H = 8'h08;
    localparam logic [7:0] TLF_ADDR_LOT_L = 8'h09;
    localparam logic [7:0] TLF_ADDR_ROT_H = 8'h0A;
    localparam logic [7:0] TLF_ADDR_ROT_L = 8'h0B;
    localparam logic [7:0] TLF_ADDR_LHL_H = 8'h0C;
    localparam logic [7:0] TLF_ADDR_LHL_L = 8'h0D;
    localparam logic [7:0] TLF_ADDR_CTRL = 8'h10;
    localparam logic [7:0] TLF_ADDR_STATUS = 8'h11;
    localparam logic [7:0] TLF_ADDR_LT_H = 8'h12;
    localparam logic [7:0] TLF_ADDR_LT_L = 8'h13;
    localparam logic [7:0] TLF_ADDR_RT_H = 8'h14;
    localparam logic [7:0] TLF_ADDR_RT_L = 8'h15;
    localparam logic [7:0] TLF_ADDR_TACH_A = 8'h16;
    localparam logic [7:0] TLF_ADDR_TACH_B = 8'h17;
    localparam logic [7:0] TLF_ADDR_LUT_BASE = 8'h20;
    localparam logic [7:0] TLF_ADDR_LUT_LAST = 8'h4F;
    localparam logic [7:0] TLF_ADDR_NV_LAST = 8'h4F;
    localparam int TLF_LUT_DEPTH = 48;
    localparam int TLF_NV_DEPTH = 80;
    localparam logic [7:0] TLF_IDEALITY_RESET = 8'h18;
    localparam logic [7:0] TLF_IDEALITY_LIMIT = 8'h40;
    localparam logic [7:0] TLF_IDEALITY_MASK = 8'h3F;
    // ctrl register fields
    localparam int TLF_CTRL_TIS = 0;
    localparam int TLF_CTRL_MTI = 1;
    localparam int TLF_CTRL_LVL_A = 2;
    localparam int TLF_CTRL_LVL_B = 3;
    localparam int TLF_CTRL_RELOAD = 7;
    localparam logic [7:0] TLF_CTRL_RESET = 8'h01;
    // status register fields
    localparam int TLF_ST_ALERT = 0;
    localparam int TLF_ST_SHUTDOWN_N = 1;
    localparam int TLF_ST_FAIL_A = 2;
    localparam int TLF_ST_FAIL_B = 3;
    localparam int TLF_ST_LOADING = 4;
    // lut index: step 2 degC above 18 degC, temp word bits 15..8 = whole degrees
    localparam logic signed [15:0] TLF_LUT_T0 = 16'sh1200;
    localparam int TLF_LUT_SHIFT = 9;
    localparam logic [15:0] TLF_TEMP_MASK = 16'hFFE0;
    // tach stall timeout
    localparam int TLF_CLK_MHZ = 100;
    localparam int TLF_STALL_MS = 250;
    localparam int TLF_STALL_CYC = TLF_STALL_MS * 1000 * TLF_CLK_MHZ;
    localparam int TLF_PWM_PERIOD = 256;
    typedef enum logic [1:0] {
        TLF_LD_IDLE = 2'b00,
        TLF_LD_COPY = 2'b01
    } tlf_load_e;
endpackage

// ---- rtl/tlf_fan_core.sv ----
// temperature-indexed fan control core with register file and limits
`timescale 1ns/100ps
`default_nettype none
module tlf_fan_core
    import tlf_pkg::*;
#(
    parameter int LUT_DEPTH = TLF_LUT_DEPTH,
    parameter int STALL_CYC = TLF_STALL_CYC
)(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register port from the serial protocol engine
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    // nonvolatile store read port, one cycle latency
    output logic nv_rd_o,
    output logic [7:0] nv_addr_o,
    input wire logic [7:0] nv_rdata_i,
    // readings from the converter, same clock
    input wire logic [15:0] local_temp_i,
    input wire logic [15:0] remote_temp_i,
    input wire logic temp_valid_i,
    // pins
    input wire logic fan_speed_in_a_i,
    input wire logic fan_speed_in_b_i,
    input wire logic fan_fail_fullspeed_n_i,
    output logic fan_fail_fullspeed_n_oe_o,
    output logic fan_fail_fullspeed_n_o,
    output logic alert_n_oe_o,
    output logic alert_n_o,
    output logic shutdown_n_oe_o,
    output logic shutdown_n_o,
    output logic pwm_oe_o,
    output logic pwm_o,
    output logic [5:0] ideality_code_o
);
    logic [7:0] fan_fail_duty_q;
    logic [7:0] diode_ideality_select_q;
    logic [7:0] applied_ideality_q;
    logic [7:0] ctrl_q;
    logic [15:0] local_high_limit_q;
    logic [15:0] remote_high_limit_q;
    logic [15:0] local_overtemp_limit_q;
    logic [15:0] remote_overtemp_limit_q;
    logic [15:0] local_temp_q;
    logic [15:0] remote_temp_q;
    logic [7:0] lut_q [LUT_DEPTH];
    logic [7:0] duty_q;
    logic alert_q;
    logic shutdown_n_q;
    logic ff1_q;
    logic ff2_q;
    tlf_load_e ld_state_q;
    logic [7:0] ld_addr_q;
    logic ld_pend_q;
    logic [7:0] ld_wr_addr_q;
    logic ld_reload_q;
    logic [7:0] tach_a_period;
    logic [7:0] tach_b_period;
    logic fail_a;
    logic fail_b;
    logic pwm_low;
    logic fan_fault;
    logic host_wr;
    logic [15:0] index_temp;
    logic [5:0] lut_index;

    function automatic logic is_lut(input logic [7:0] a);
        return (a >= TLF_ADDR_LUT_BASE) && (a <= TLF_ADDR_LUT_LAST);
    endfunction

    function automatic logic [5:0] lut_slot(input logic [7:0] a);
        return 6'(a - TLF_ADDR_LUT_BASE);
    endfunction

    // reading greater than limit, signed, strictly
    function automatic logic over(input logic [15:0] t, input logic [15:0] lim);
        return $signed(t) > $signed(lim);
    endfunction

    // register writes from the host and from the reload share one path
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    // the last two reload writes land after the sequencer is idle; host waits for them
    assign host_wr = reg_wr_i && (ld_state_q == TLF_LD_IDLE) && !nv_rd_o && !ld_pend_q;
    assign wr_en = ld_pend_q || host_wr;
    assign wr_addr = ld_pend_q ? ld_wr_addr_q : reg_addr_i;
    assign wr_data = ld_pend_q ? nv_rdata_i : reg_wdata_i;

    // reload sequencer copies the nonvolatile image into working registers
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ld_state_q <= TLF_LD_COPY;
            ld_addr_q <= 8'h0;
            ld_pend_q <= 1'b0;
            ld_wr_addr_q <= 8'h0;
            nv_rd_o <= 1'b0;
            nv_addr_o <= 8'h0;
        end
        else if (ce_i)
        begin
            ld_pend_q <= nv_rd_o;
            ld_wr_addr_q <= nv_addr_o;
            nv_rd_o <= 1'b0;
            case (ld_state_q)
                TLF_LD_IDLE:
                begin
                    if (ld_reload_q)
                    begin
                        ld_state_q <= TLF_LD_COPY;
                        ld_addr_q <= 8'h0;
                    end
                end
                TLF_LD_COPY:
                begin
                    nv_rd_o <= 1'b1;
                    nv_addr_o <= ld_addr_q;
                    ld_addr_q <= ld_addr_q + 8'h1;
                    if (ld_addr_q == TLF_ADDR_NV_LAST)
                    begin
                        ld_state_q <= TLF_LD_IDLE;
                    end
                end
                default:
                begin
                    ld_state_q <= TLF_LD_IDLE;
                end
            endcase
        end
    end

    // reload request bit self-clears once the copy begins
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ld_reload_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (host_wr && reg_addr_i == TLF_ADDR_CTRL)
            begin
                ld_reload_q <= reg_wdata_i[TLF_CTRL_RELOAD];
            end
            else if (ld_state_q == TLF_LD_IDLE)
            begin
                ld_reload_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fan_fail_duty_q <= 8'hFF;
            diode_ideality_select_q <= TLF_IDEALITY_RESET;
            ctrl_q <= TLF_CTRL_RESET;
            local_high_limit_q <= 16'h0;
            remote_high_limit_q <= 16'h0;
            local_overtemp_limit_q <= 16'h0;
            remote_overtemp_limit_q <= 16'h0;
        end
        else if (ce_i && wr_en)
        begin
            if (wr_addr == TLF_ADDR_FAN_FAIL_DUTY)
                fan_fail_duty_q <= wr_data;
            else if (wr_addr == TLF_ADDR_IDEALITY)
                diode_ideality_select_q <= wr_data & TLF_IDEALITY_MASK;
            else if (wr_addr == TLF_ADDR_CTRL)
                ctrl_q <= {1'b0, wr_data[6:0]};
            else if (wr_addr == TLF_ADDR_LHL_H)
                local_high_limit_q[15:8] <= wr_data;
            else if (wr_addr == TLF_ADDR_LHL_L)
                local_high_limit_q[7:0] <= wr_data & TLF_TEMP_MASK[7:0];
            else if (wr_addr == TLF_ADDR_RHL_H)
                remote_high_limit_q[15:8] <= wr_data;
            else if (wr_addr == TLF_ADDR_RHL_L)
                remote_high_limit_q[7:0] <= wr_data & TLF_TEMP_MASK[7:0];
            else if (wr_addr == TLF_ADDR_LOT_H)
                local_overtemp_limit_q[15:8] <= wr_data;
            else if (wr_addr == TLF_ADDR_LOT_L)
                local_overtemp_limit_q[7:0] <= wr_data & TLF_TEMP_MASK[7:0];
            else if (wr_addr == TLF_ADDR_ROT_H)
                remote_overtemp_limit_q[15:8] <= wr_data;
            else if (wr_addr == TLF_ADDR_ROT_L)
                remote_overtemp_limit_q[7:0] <= wr_data & TLF_TEMP_MASK[7:0];
        end
    end

    // the table has no reset; the reload fills it before first use
    always_ff @(posedge clk_sys_i)
    begin
        if (ce_i && wr_en && is_lut(wr_addr))
        begin
            lut_q[lut_slot(wr_addr)] <= wr_data;
        end
    end

    // an out-of-range select keeps the last valid code; judged on the unmasked write
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            applied_ideality_q <= TLF_IDEALITY_RESET;
        end
        else if (ce_i && wr_en && wr_addr == TLF_ADDR_IDEALITY && wr_data < TLF_IDEALITY_LIMIT)
        begin
            applied_ideality_q <= wr_data;
        end
    end
    assign ideality_code_o = applied_ideality_q[5:0];

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            local_temp_q <= 16'h0;
            remote_temp_q <= 16'h0;
        end
        else if (ce_i && temp_valid_i)
        begin
            local_temp_q <= local_temp_i & TLF_TEMP_MASK;
            remote_temp_q <= remote_temp_i & TLF_TEMP_MASK;
        end
    end

    always_comb
    begin
        if (ctrl_q[TLF_CTRL_MTI])
            index_temp = over(remote_temp_q, local_temp_q) ? remote_temp_q : local_temp_q;
        else if (ctrl_q[TLF_CTRL_TIS])
            index_temp = remote_temp_q;
        else
            index_temp = local_temp_q;
        if ($signed(index_temp) < TLF_LUT_T0)
            lut_index = 6'h0;
        else if (((index_temp - TLF_LUT_T0) >> TLF_LUT_SHIFT) >= 16'(LUT_DEPTH - 1))
            lut_index = 6'(LUT_DEPTH - 1);
        else
            lut_index = 6'(((index_temp - TLF_LUT_T0) >> TLF_LUT_SHIFT) + 16'h1);
    end

    // external full-speed request on the shared fail pin
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ff1_q <= 1'b1;
            ff2_q <= 1'b1;
        end
        else if (ce_i)
        begin
            ff1_q <= fan_fail_fullspeed_n_i;
            ff2_q <= ff1_q;
        end
    end

    assign fan_fault = fail_a | fail_b;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            duty_q <= 8'h0;
            alert_q <= 1'b0;
            shutdown_n_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (fan_fault)
                duty_q <= fan_fail_duty_q;
            else if (!ff2_q && !fan_fail_fullspeed_n_oe_o)
                duty_q <= 8'hFF;
            else
                duty_q <= lut_q[lut_index];
            alert_q <= over(local_temp_q, local_high_limit_q)
                || over(remote_temp_q, remote_high_limit_q);
            shutdown_n_q <= over(local_temp_q, local_overtemp_limit_q)
                || over(remote_temp_q, remote_overtemp_limit_q);
        end
    end

    tlf_tach_mon #(.STALL_CYC(STALL_CYC)) u_tach_a (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tach_i(fan_speed_in_a_i),
        .level_mode_i(ctrl_q[TLF_CTRL_LVL_A]),
        .period_o(tach_a_period),
        .fail_o(fail_a)
    );

    tlf_tach_mon #(.STALL_CYC(STALL_CYC)) u_tach_b (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tach_i(fan_speed_in_b_i),
        .level_mode_i(ctrl_q[TLF_CTRL_LVL_B]),
        .period_o(tach_b_period),
        .fail_o(fail_b)
    );

    tlf_pwm_gen u_pwm (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .duty_i(duty_q),
        .drive_low_o(pwm_low)
    );

    // open-drain pins: output constant low, enable pulls
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pwm_oe_o <= 1'b0;
            pwm_o <= 1'b0;
            alert_n_oe_o <= 1'b0;
            alert_n_o <= 1'b0;
            shutdown_n_oe_o <= 1'b0;
            shutdown_n_o <= 1'b0;
            fan_fail_fullspeed_n_oe_o <= 1'b0;
            fan_fail_fullspeed_n_o <= 1'b0;
        end
        else if (ce_i)
        begin
            pwm_oe_o <= pwm_low && (ld_state_q == TLF_LD_IDLE);
            alert_n_oe_o <= alert_q;
            shutdown_n_oe_o <= shutdown_n_q;
            fan_fail_fullspeed_n_oe_o <= fan_fault;
        end
    end

    // register reads answer one cycle after the strobe
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h0;
            reg_ack_o <= 1'b0;
        end
        else if (ce_i)
        begin
            reg_ack_o <= reg_rd_i || reg_wr_i;
            if (reg_rd_i)
            begin
                if (reg_addr_i == TLF_ADDR_FAN_FAIL_DUTY)
                    reg_rdata_o <= fan_fail_duty_q;
                else if (reg_addr_i == TLF_ADDR_IDEALITY)
                    reg_rdata_o <= diode_ideality_select_q;
                else if (reg_addr_i == TLF_ADDR_RHL_H)
                    reg_rdata_o <= remote_high_limit_q[15:8];
                else if (reg_addr_i == TLF_ADDR_RHL_L)
                    reg_rdata_o <= remote_high_limit_q[7:0];
                else if (reg_addr_i == TLF_ADDR_LOT_H)
                    reg_rdata_o <= local_overtemp_limit_q[15:8];
                else if (reg_addr_i == TLF_ADDR_LOT_L)
                    reg_rdata_o <= local_overtemp_limit_q[7:0];
                else if (reg_addr_i == TLF_ADDR_ROT_H)
                    reg_rdata_o <= remote_overtemp_limit_q[15:8];
                else if (reg_addr_i == TLF_ADDR_ROT_L)
                    reg_rdata_o <= remote_overtemp_limit_q[7:0];
                else if (reg_addr_i == TLF_ADDR_LHL_H)
                    reg_rdata_o <= local_high_limit_q[15:8];
                else if (reg_addr_i == TLF_ADDR_LHL_L)
                    reg_rdata_o <= local_high_limit_q[7:0];
                else if (reg_addr_i == TLF_ADDR_CTRL)
                    reg_rdata_o <= {ld_reload_q, ctrl_q[6:0]};
                else if (reg_addr_i == TLF_ADDR_STATUS)
                    reg_rdata_o <= {3'h0, ld_state_q != TLF_LD_IDLE, fail_b, fail_a,
                        shutdown_n_q, alert_q};
                else if (reg_addr_i == TLF_ADDR_LT_H)
                    reg_rdata_o <= local_temp_q[15:8];
                else if (reg_addr_i == TLF_ADDR_LT_L)
                    reg_rdata_o <= local_temp_q[7:0];
                else if (reg_addr_i == TLF_ADDR_RT_H)
                    reg_rdata_o <= remote_temp_q[15:8];
                else if (reg_addr_i == TLF_ADDR_RT_L)
                    reg_rdata_o <= remote_temp_q[7:0];
                else if (reg_addr_i == TLF_ADDR_TACH_A)
                    reg_rdata_o <= tach_a_period;
                else if (reg_addr_i == TLF_ADDR_TACH_B)
                    reg_rdata_o <= tach_b_period;
                else if (is_lut(reg_addr_i))
                    reg_rdata_o <= lut_q[lut_slot(reg_addr_i)];
                else
                    reg_rdata_o <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/tlf_pwm_gen.sv ----
// free-running pwm generator, duty 0..254 of 256, duty 255 drives full on
`timescale 1ns/100ps
`default_nettype none
module tlf_pwm_gen
    import tlf_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] duty_i,
    output logic drive_low_o
);
    logic [7:0] phase_q;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            phase_q <= 8'h0;
            drive_low_o <= 1'b0;
        end
        else if (ce_i)
        begin
            phase_q <= phase_q + 8'h1;
            drive_low_o <= ~((phase_q < duty_i) || (duty_i == 8'hFF));
        end
    end
endmodule
`default_nettype wire

// ---- rtl/tlf_tach_mon.sv ----
// one tachometer channel: pulse period measurement or level rotation check
`timescale 1ns/100ps
`default_nettype none
module tlf_tach_mon
    import tlf_pkg::*;
#(
    parameter int STALL_CYC = TLF_STALL_CYC
)(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tach_i,
    input wire logic level_mode_i,
    output logic [7:0] period_o,
    output logic fail_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic [31:0] cnt_q;
    logic rise;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else if (ce_i)
        begin
            s1_q <= tach_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign rise = s2_q & ~s3_q;

    // a pulse edge restarts the stall count; level mode treats high as rotor locked
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 32'h0;
            period_o <= 8'h0;
            fail_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (level_mode_i)
            begin
                cnt_q <= 32'h0;
                fail_o <= s2_q;
            end
            else if (rise)
            begin
                period_o <= cnt_q[31:24] | {7'h0, |cnt_q[23:16]};
                cnt_q <= 32'h0;
                fail_o <= 1'b0;
            end
            else if (cnt_q >= 32'(STALL_CYC))
            begin
                fail_o <= 1'b1;
            end
            else
            begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/tlf_fan_core_assertions.sv ----
// port-level checker for the fan control core
`timescale 1ns/100ps
`default_nettype none
module tlf_fan_core_assertions
    import tlf_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic [15:0] local_temp_i,
    input wire logic temp_valid_i,
    input wire logic alert_n_o,
    input wire logic shutdown_n_o,
    input wire logic pwm_o,
    input wire logic pwm_oe_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence rd_at(logic [7:0] a);
        reg_rd_i && ce_i && reg_addr_i == a;
    endsequence
    sequence temp_load;
        temp_valid_i && ce_i;
    endsequence
    ack_follow_a: assert property (reg_rd_i && ce_i |=> reg_ack_o)
        else $error("read not acked");
    ack_cause_a: assert property (reg_ack_o |-> $past(reg_rd_i || reg_wr_i))
        else $error("ack without request");
    rdata_hold_a: assert property (!(reg_rd_i && ce_i) |=> $stable(reg_rdata_o))
        else $error("read data moved");
    ideality_top_a: assert property (rd_at(TLF_ADDR_IDEALITY)
        |=> reg_rdata_o[7:6] == 2'h0) else $error("ideality top bits set");
    low_zero_a: assert property (rd_at(TLF_ADDR_LT_L) or rd_at(TLF_ADDR_RT_L)
        |=> reg_rdata_o[4:0] == 5'h00) else $error("low bits not zero");
    unmapped_a: assert property (rd_at(8'hFF) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    od_data_a: assert property ({alert_n_o, shutdown_n_o, pwm_o} == 3'h0)
        else $error("open drain data high");
    freeze_a: assert property (!ce_i |=> $stable(pwm_oe_o))
        else $error("pwm moved while frozen");
    temp_read_a: assert property (temp_load ##1 rd_at(TLF_ADDR_LT_H) |=>
        {reg_rdata_o, 8'h00} == ($past(local_temp_i, 2) & 16'hFF00)) else $error("local byte");
endmodule
bind tlf_fan_core tlf_fan_core_assertions chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .local_temp_i(local_temp_i),
    .temp_valid_i(temp_valid_i), .alert_n_o(alert_n_o), .shutdown_n_o(shutdown_n_o),
    .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o));
`default_nettype wire

// ---- sim/tlf_fan_core_test.sv ----
// self-checking bench for the fan control core
`timescale 1ns/100ps
`default_nettype none
module tlf_fan_core_test
    import tlf_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1, wr = 1'b0, rd = 1'b0, tv = 1'b0, ext_n = 1'b1;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, nvd, nva;
    logic [15:0] lt = 16'h0000, rt = 16'h0000, lf = 16'h0007, got, t;
    logic [1:0] run = 2'b11, stuck = 2'b00;
    logic ack, nvr, ffoe, aoe, soe, poe, ta, tb;
    logic [5:0] idc;
    logic [15:0] lim [4] = '{16'h1900, 16'h1900, 16'hFF00, 16'hFF00};
    logic [15:0] tmp [4] = '{16'h1900, 16'h1920, 16'h0000, 16'hE700};
    logic [3:0] ex = 4'b0110;
    int fails = 0, n_checks = 0, cyc = 0;
    tlf_fan_core #(.STALL_CYC(50)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
        .reg_ack_o(ack), .nv_rd_o(nvr), .nv_addr_o(nva), .nv_rdata_i(nvd), .local_temp_i(lt),
        .remote_temp_i(rt), .temp_valid_i(tv), .fan_speed_in_a_i(ta), .fan_speed_in_b_i(tb),
        .fan_fail_fullspeed_n_i(ext_n & !ffoe), .fan_fail_fullspeed_n_oe_o(ffoe),
        .fan_fail_fullspeed_n_o(), .alert_n_oe_o(aoe), .alert_n_o(), .shutdown_n_oe_o(soe),
        .shutdown_n_o(), .pwm_oe_o(poe), .pwm_o(), .ideality_code_o(idc));
    tlf_far_model far (.clk_sys_i(clk_sys_i), .nv_rd_i(nvr), .nv_addr_i(nva),
        .nv_rdata_o(nvd), .run_i(run), .stuck_i(stuck), .tach_a_o(ta), .tach_b_o(tb));
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            wrap_up();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] lut_exp(input logic signed [15:0] x);
        int i;
        i = (x < 16'sh1200) ? 0 : ((x - 16'sh1200) >>> 9) + 1;
        return (i > 47) ? 8'hEB : 8'(i * 5);
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    task automatic rreg(input logic [7:0] a);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        got = {7'h00, ack, rdata};
        tick(1);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rreg(a);
        chk(got, {8'h01, e});
    endtask
    task automatic temp(input logic [15:0] l, input logic [15:0] r);
        lt = l;
        rt = r;
        tv = 1'b1;
        tick(1);
        tv = 1'b0;
    endtask
    // skip 300 cycles, more than one 256-cycle pwm period, so a duty change mid-period is not counted
    task automatic duty(input logic [7:0] d);
        int h;
        h = 0;
        tick(300);
        repeat (256)
        begin
            h += int'(!poe);
            tick(1);
        end
        chk(16'(h), (d == 8'hFF) ? 16'h0100 : {8'h00, d});
    endtask
    task automatic reset();
        rst_i = 1'b1;
        tick(3);
        rst_i = 1'b0;
        rreg(TLF_ADDR_STATUS);
        repeat (150) if (got[TLF_ST_LOADING] !== 1'b0) rreg(TLF_ADDR_STATUS);
        chk(16'(got[TLF_ST_LOADING]), 16'h0000);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        reset();
        rchk(TLF_ADDR_IDEALITY, 8'h18);
        chk(16'(idc), 16'h0018);
        rchk(TLF_ADDR_LUT_BASE + 8'h05, 8'h19);
        rchk(TLF_ADDR_LUT_LAST, 8'hEB);
        rchk(8'hFF, 8'h00);
        wreg(TLF_ADDR_IDEALITY, 8'h3A);
        rchk(TLF_ADDR_IDEALITY, 8'h3A);
        wreg(TLF_ADDR_IDEALITY, 8'h45);
        chk(16'(idc), 16'h003A);
        rchk(TLF_ADDR_IDEALITY, 8'h05);
        wreg(TLF_ADDR_CTRL, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            lf = lfsr(lf);
            // byte swap moves the young register's bits into the whole degrees
            t = (i == 0) ? 16'hFFE0 : {lf[7:0], lf[15:8]};
            temp(t, ~t);
            rchk(TLF_ADDR_LT_H, t[15:8]);
            rchk(TLF_ADDR_LT_L, t[7:0] & 8'hE0);
            rchk(TLF_ADDR_RT_H, ~t[15:8]);
            rchk(TLF_ADDR_RT_L, ~t[7:0] & 8'hE0);
            duty(lut_exp(t));
        end
        temp(16'hEC00, 16'h2800);
        for (int m = 1; m < 4; m++)
        begin
            wreg(TLF_ADDR_CTRL, 8'(m));
            duty(8'h3C);
        end
        ext_n = 1'b0;
        duty(8'hFF);
        ext_n = 1'b1;
        for (int k = 0; k < 2; k++)
            for (int j = 0; j < 4; j++)
            begin
                wreg(k ? TLF_ADDR_ROT_H : TLF_ADDR_LHL_H, lim[j][15:8]);
                wreg(k ? TLF_ADDR_ROT_L : TLF_ADDR_LHL_L, lim[j][7:0]);
                temp(k ? 16'h0000 : tmp[j], k ? tmp[j] : 16'h0000);
                tick(4);
                chk(16'(k ? soe : aoe), 16'(ex[j]));
            end
        run = 2'b01;
        tick(80);
        chk(16'(ffoe), 16'h0001);
        wreg(TLF_ADDR_FAN_FAIL_DUTY, 8'hC0);
        duty(8'hC0);
        wreg(TLF_ADDR_IDEALITY, 8'h3A);
        wreg(TLF_ADDR_CTRL, 8'h80);
        tick(100);
        rchk(TLF_ADDR_IDEALITY, 8'h18);
        ce = 1'b0;
        tick(20);
        ce = 1'b1;
        run = 2'b10;
        reset();
        wreg(TLF_ADDR_CTRL, 8'h05);
        tick(80);
        chk(16'(ffoe), 16'h0000);
        stuck = 2'b01;
        tick(80);
        chk(16'(ffoe), 16'h0001);
        wrap_up();
    end
endmodule
`default_nettype wire

// ---- sim/tlf_far_model.sv ----
// far side: preset nonvolatile store and two fan tach outputs
`timescale 1ns/100ps
`default_nettype none
module tlf_far_model
    import tlf_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nv_rd_i,
    input wire logic [7:0] nv_addr_i,
    output logic [7:0] nv_rdata_o,
    input wire logic [1:0] run_i,
    input wire logic [1:0] stuck_i,
    output logic tach_a_o,
    output logic tach_b_o
);
    logic [7:0] cnt_q = 8'h00;
    // profile: remote index, default ideality, entry k of the table holds 5*k
    function automatic logic [7:0] nv_val(input logic [7:0] a);
        if (a == TLF_ADDR_IDEALITY)
            return 8'h18;
        if (a == TLF_ADDR_CTRL)
            return 8'h01;
        if (a >= TLF_ADDR_LUT_BASE)
            return 8'((a - TLF_ADDR_LUT_BASE) * 5);
        return 8'h7F;
    endfunction
    // data only valid the cycle after a read; otherwise it keeps toggling
    always_ff @(posedge clk_sys_i)
    begin
        nv_rdata_o <= nv_rd_i ? nv_val(nv_addr_i) : ~nv_rdata_o;
        cnt_q <= cnt_q + 8'h01;
    end
    assign tach_a_o = run_i[0] ? cnt_q[3] : stuck_i[0];
    assign tach_b_o = run_i[1] ? cnt_q[3] : stuck_i[1];
endmodule
`default_nettype wire
